// ==== rtl/lcd_cmd_pkg.sv ====
// Shared constants for the segment display command target and its bus controller
package lcd_cmd_pkg;
    localparam int CLK_PERIOD_NS = 20;
    localparam int SCL_PERIOD_NS = 2500;
    localparam int SCL_QUARTER_CYCLES = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
    localparam logic [7:0] QUARTER_LAST = 8'(SCL_QUARTER_CYCLES - 1);
    localparam logic [5:0] TARGET_ADDR_HI = 6'h1c;
    localparam logic [3:0] DEVSEL_PATTERN = 4'hc;
    localparam logic [4:0] BANKSEL_PATTERN = 5'h1e;
    localparam logic [3:0] BLINK_PATTERN = 4'he;
    localparam int CONT_BIT = 7;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [2:0] SUBADDR_RESET = 3'h0;
    localparam logic BANK_RESET = 1'b0;
    localparam logic ALT_BLINK_RESET = 1'b0;
    localparam logic [1:0] BLINK_FREQ_RESET = 2'h0;
    typedef logic [1:0] drive_mode_t;
    localparam drive_mode_t DRIVE_STATIC = 2'h1;
    localparam drive_mode_t DRIVE_MUX2 = 2'h2;
    localparam drive_mode_t DRIVE_MUX3 = 2'h3;
    localparam drive_mode_t DRIVE_MUX4 = 2'h0;
    localparam logic [3:0] REG_CMD_OFFSET = 4'h0;
    localparam logic [3:0] REG_STATUS_OFFSET = 4'h4;
    localparam int CMD_START_BIT = 8;
    localparam int CMD_STOP_BIT = 9;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Bank switching exists only where an alternate bank is free
    function automatic logic bank_cmds_allowed(input drive_mode_t mode);
        return (mode == DRIVE_STATIC) || (mode == DRIVE_MUX2);
    endfunction : bank_cmds_allowed
endpackage : lcd_cmd_pkg

// ==== rtl/lcd_link_if.sv ====
// Two-wire open-drain link between the bus controller and the display target
`timescale 1ns/1ps
`default_nettype none
interface lcd_link_if;
    logic scl_o;
    logic scl_oe;
    logic host_sda_o;
    logic host_sda_oe;
    logic tgt_sda_o;
    logic tgt_sda_oe;
    logic scl;
    logic sda;

    // Pull-ups: a line is low only while some end drives it low
    assign scl = !(scl_oe && !scl_o);
    assign sda = !((host_sda_oe && !host_sda_o) || (tgt_sda_oe && !tgt_sda_o));

    modport controller (output scl_o, output scl_oe, output host_sda_o, output host_sda_oe, input sda);
    modport target (output tgt_sda_o, output tgt_sda_oe, input scl, input sda);
endinterface : lcd_link_if
`default_nettype wire

// ==== rtl/lcd_cmd_target.sv ====
// Receive-only two-wire target with command decoder and display controller state
//
// Register access over AXI4-Lite and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module lcd_cmd_target (
    input wire logic aclk,
    input wire logic aresetn,
    lcd_link_if.target link,
    input wire logic hw_subaddr_pin_0,
    input wire logic hw_subaddr_pin_1,
    input wire logic hw_subaddr_pin_2,
    input wire logic target_addr_select_pin,
    input wire lcd_cmd_pkg::drive_mode_t drive_mode,
    output logic [2:0] subaddr_count,
    output logic in_bank_sel,
    output logic out_bank_sel,
    output logic alt_bank_blink_bit,
    output logic [1:0] blink_freq_field,
    output logic alt_blink_active,
    output logic data_wr,
    output logic [7:0] data_byte,
    output logic data_in_bank,
    output logic ext_cmd_valid,
    output logic [7:0] ext_cmd_byte,
    output logic selected
);
    import lcd_cmd_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_RX, ST_ACK, ST_IGNORE} tgt_state_t;
    typedef enum logic [1:0] {PH_ADDR, PH_CMD, PH_DATA} byte_phase_t;

    // Synchronisers for bus lines and strap pins
    logic [1:0] scl_sync_reg;
    logic [1:0] sda_sync_reg;
    logic [3:0] pin_meta_reg;
    logic [3:0] pin_sync_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
            pin_meta_reg <= 4'h0;
            pin_sync_reg <= 4'h0;
        end else begin
            scl_sync_reg <= {scl_sync_reg[0], link.scl};
            sda_sync_reg <= {sda_sync_reg[0], link.sda};
            pin_meta_reg <= {target_addr_select_pin, hw_subaddr_pin_2, hw_subaddr_pin_1, hw_subaddr_pin_0};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    logic scl_now;
    logic sda_now;
    logic [2:0] hw_subaddr;
    logic addr_sel;
    assign scl_now = scl_sync_reg[1];
    assign sda_now = sda_sync_reg[1];
    assign hw_subaddr = pin_sync_reg[2:0];
    assign addr_sel = pin_sync_reg[3];

    tgt_state_t state_reg, state_next;
    byte_phase_t phase_reg, phase_next;
    logic scl_prev_reg, scl_prev_next;
    logic sda_prev_reg, sda_prev_next;
    logic [3:0] bit_cnt_reg, bit_cnt_next;
    logic [7:0] shift_reg, shift_next;
    logic ack_oe_reg, ack_oe_next;
    logic sel_reg, sel_next;
    logic [2:0] subaddr_reg, subaddr_next;
    logic in_bank_reg, in_bank_next;
    logic out_bank_reg, out_bank_next;
    logic alt_blink_reg, alt_blink_next;
    logic [1:0] blink_freq_reg, blink_freq_next;
    logic alt_active_reg, alt_active_next;
    logic data_wr_reg, data_wr_next;
    logic [7:0] data_byte_reg, data_byte_next;
    logic data_bank_reg, data_bank_next;
    logic ext_valid_reg, ext_valid_next;
    logic [7:0] ext_byte_reg, ext_byte_next;

    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    assign scl_rise = scl_now && !scl_prev_reg;
    assign scl_fall = !scl_now && scl_prev_reg;
    assign start_cond = scl_now && scl_prev_reg && sda_prev_reg && !sda_now;
    assign stop_cond = scl_now && scl_prev_reg && !sda_prev_reg && sda_now;

    always_comb begin
        state_next = state_reg;
        phase_next = phase_reg;
        scl_prev_next = scl_now;
        sda_prev_next = sda_now;
        bit_cnt_next = bit_cnt_reg;
        shift_next = shift_reg;
        ack_oe_next = ack_oe_reg;
        sel_next = sel_reg;
        subaddr_next = subaddr_reg;
        in_bank_next = in_bank_reg;
        out_bank_next = out_bank_reg;
        alt_blink_next = alt_blink_reg;
        blink_freq_next = blink_freq_reg;
        data_wr_next = 1'b0;
        data_byte_next = data_byte_reg;
        data_bank_next = data_bank_reg;
        ext_valid_next = 1'b0;
        ext_byte_next = ext_byte_reg;
        if (start_cond) begin
            // A repeated start also lands here and restarts address matching
            state_next = ST_RX;
            phase_next = PH_ADDR;
            bit_cnt_next = 4'h0;
            ack_oe_next = 1'b0;
            sel_next = 1'b0;
        end else if (stop_cond) begin
            state_next = ST_IDLE;
            ack_oe_next = 1'b0;
            sel_next = 1'b0;
        end else begin
            case (state_reg)
                ST_RX: begin
                    if (scl_rise && bit_cnt_reg != BITS_PER_BYTE) begin
                        shift_next = {shift_reg[6:0], sda_now};
                        bit_cnt_next = bit_cnt_reg + 4'h1;
                    end else if (scl_fall && bit_cnt_reg == BITS_PER_BYTE) begin
                        state_next = ST_ACK;
                        case (phase_reg)
                            PH_ADDR: begin
                                if (shift_reg[7:2] == TARGET_ADDR_HI && shift_reg[1] == addr_sel
                                    && !shift_reg[0]) begin
                                    ack_oe_next = 1'b1;
                                    sel_next = 1'b1;
                                    phase_next = PH_CMD;
                                end else begin
                                    // Reads and foreign addresses are not answered at all
                                    state_next = ST_IGNORE;
                                end
                            end
                            PH_CMD: begin
                                ack_oe_next = 1'b1;
                                if (!shift_reg[CONT_BIT]) begin
                                    phase_next = PH_DATA;
                                end
                                if (shift_reg[6:3] == DEVSEL_PATTERN) begin
                                    subaddr_next = shift_reg[2:0];
                                end else if (shift_reg[6:2] == BANKSEL_PATTERN) begin
                                    if (bank_cmds_allowed(drive_mode)) begin
                                        in_bank_next = shift_reg[1];
                                        out_bank_next = shift_reg[0];
                                    end
                                end else if (shift_reg[6:3] == BLINK_PATTERN) begin
                                    alt_blink_next = shift_reg[2];
                                    blink_freq_next = shift_reg[1:0];
                                end else begin
                                    // Mode-set and data pointer go to the rest of the controller
                                    ext_valid_next = 1'b1;
                                    ext_byte_next = shift_reg;
                                end
                            end
                            PH_DATA: begin
                                if (subaddr_reg == hw_subaddr) begin
                                    ack_oe_next = 1'b1;
                                    data_wr_next = 1'b1;
                                    data_byte_next = shift_reg;
                                    data_bank_next = in_bank_reg;
                                end
                            end
                            default: begin
                                state_next = ST_IGNORE;
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    // Acknowledge held through the whole high phase, released on the fall
                    if (scl_fall) begin
                        state_next = ST_RX;
                        bit_cnt_next = 4'h0;
                        ack_oe_next = 1'b0;
                    end
                end
                default: begin
                    ack_oe_next = 1'b0;
                end
            endcase
        end
        alt_active_next = alt_blink_next && bank_cmds_allowed(drive_mode);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= ST_IDLE;
            phase_reg <= PH_ADDR;
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            ack_oe_reg <= 1'b0;
            sel_reg <= 1'b0;
            subaddr_reg <= SUBADDR_RESET;
            in_bank_reg <= BANK_RESET;
            out_bank_reg <= BANK_RESET;
            alt_blink_reg <= ALT_BLINK_RESET;
            blink_freq_reg <= BLINK_FREQ_RESET;
            alt_active_reg <= 1'b0;
            data_wr_reg <= 1'b0;
            data_byte_reg <= 8'h00;
            data_bank_reg <= BANK_RESET;
            ext_valid_reg <= 1'b0;
            ext_byte_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            phase_reg <= phase_next;
            scl_prev_reg <= scl_prev_next;
            sda_prev_reg <= sda_prev_next;
            bit_cnt_reg <= bit_cnt_next;
            shift_reg <= shift_next;
            ack_oe_reg <= ack_oe_next;
            sel_reg <= sel_next;
            subaddr_reg <= subaddr_next;
            in_bank_reg <= in_bank_next;
            out_bank_reg <= out_bank_next;
            alt_blink_reg <= alt_blink_next;
            blink_freq_reg <= blink_freq_next;
            alt_active_reg <= alt_active_next;
            data_wr_reg <= data_wr_next;
            data_byte_reg <= data_byte_next;
            data_bank_reg <= data_bank_next;
            ext_valid_reg <= ext_valid_next;
            ext_byte_reg <= ext_byte_next;
        end
    end

    // Open drain: only ever pulls the data line low
    assign link.tgt_sda_o = 1'b0;
    assign link.tgt_sda_oe = ack_oe_reg;
    assign subaddr_count = subaddr_reg;
    assign in_bank_sel = in_bank_reg;
    assign out_bank_sel = out_bank_reg;
    assign alt_bank_blink_bit = alt_blink_reg;
    assign blink_freq_field = blink_freq_reg;
    assign alt_blink_active = alt_active_reg;
    assign data_wr = data_wr_reg;
    assign data_byte = data_byte_reg;
    assign data_in_bank = data_bank_reg;
    assign ext_cmd_valid = ext_valid_reg;
    assign ext_cmd_byte = ext_byte_reg;
    assign selected = sel_reg;
endmodule : lcd_cmd_target
`default_nettype wire

// ==== rtl/lcd_bus_controller.sv ====
// Two-wire bus controller driven by software over AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
module lcd_bus_controller (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [3:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    lcd_link_if.controller link
);
    import lcd_cmd_pkg::*;

    typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} host_state_t;

    function automatic logic reg_mapped(input logic [3:0] a);
        return (a == REG_CMD_OFFSET) || (a == REG_STATUS_OFFSET);
    endfunction : reg_mapped

    // Line levels per quarter bit: {scl low, sda low}
    function automatic logic [1:0] line_levels(input host_state_t s, input logic [1:0] q, input logic bit_low);
        case (s)
            H_START: return (q == 2'h0) ? 2'b10 : ((q == 2'h1) ? 2'b00 : 2'b01);
            H_BIT: return {!q[1], bit_low};
            H_STOP: return (q == 2'h0) ? 2'b11 : ((q == 2'h1) ? 2'b01 : 2'b00);
            default: return 2'b00;
        endcase
    endfunction : line_levels

    logic [1:0] sda_sync_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sda_sync_reg <= 2'h3;
        end else begin
            sda_sync_reg <= {sda_sync_reg[0], link.sda};
        end
    end

    host_state_t state_reg, state_next;
    logic [7:0] div_reg, div_next;
    logic [1:0] q_reg, q_next;
    logic [3:0] idx_reg, idx_next;
    logic [7:0] tx_reg, tx_next;
    logic stop_pend_reg, stop_pend_next;
    logic [1:0] lines_reg, lines_next;
    logic nack_reg, nack_next;
    logic [9:0] cmd_reg, cmd_next;
    logic aw_have_reg, aw_have_next;
    logic [3:0] aw_addr_reg, aw_addr_next;
    logic w_have_reg, w_have_next;
    logic [31:0] w_data_reg, w_data_next;
    logic [3:0] w_strb_reg, w_strb_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;
    logic tick;
    logic cmd_go;

    assign awready = !aw_have_reg && !bvalid_reg;
    assign wready = !w_have_reg && !bvalid_reg;
    assign arready = !rvalid_reg;
    assign tick = (div_reg == QUARTER_LAST);

    always_comb begin
        aw_have_next = aw_have_reg;
        aw_addr_next = aw_addr_reg;
        w_have_next = w_have_reg;
        w_data_next = w_data_reg;
        w_strb_next = w_strb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        cmd_next = cmd_reg;
        cmd_go = 1'b0;
        if (awvalid && awready) begin
            aw_have_next = 1'b1;
            aw_addr_next = awaddr;
        end
        if (wvalid && wready) begin
            w_have_next = 1'b1;
            w_data_next = wdata;
            w_strb_next = wstrb;
        end
        if (aw_have_reg && w_have_reg) begin
            aw_have_next = 1'b0;
            w_have_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = reg_mapped(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
            // A command while busy or without byte lanes 0 and 1 both enabled is dropped
            if (aw_addr_reg == REG_CMD_OFFSET && w_strb_reg[1:0] == 2'b11 && state_reg == H_IDLE) begin
                cmd_go = 1'b1;
                cmd_next = w_data_reg[9:0];
            end
        end else if (bvalid_reg && bready) begin
            bvalid_next = 1'b0;
        end
        if (arvalid && arready) begin
            rvalid_next = 1'b1;
            rresp_next = reg_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
            if (araddr == REG_CMD_OFFSET) begin
                rdata_next = {22'h0, cmd_reg};
            end else if (araddr == REG_STATUS_OFFSET) begin
                rdata_next = {30'h0, nack_reg, state_reg != H_IDLE};
            end else begin
                rdata_next = 32'h0;
            end
        end else if (rvalid_reg && rready) begin
            rvalid_next = 1'b0;
        end
    end

    always_comb begin
        state_next = state_reg;
        div_next = (state_reg == H_IDLE || tick) ? 8'h00 : div_reg + 8'h01;
        q_next = q_reg;
        idx_next = idx_reg;
        tx_next = tx_reg;
        stop_pend_next = stop_pend_reg;
        nack_next = nack_reg;
        if (state_reg == H_IDLE) begin
            if (cmd_go) begin
                tx_next = w_data_reg[7:0];
                stop_pend_next = w_data_reg[CMD_STOP_BIT];
                state_next = w_data_reg[CMD_START_BIT] ? H_START : H_BIT;
                q_next = 2'h0;
                idx_next = 4'h0;
                nack_next = 1'b0;
            end
        end else if (tick) begin
            q_next = q_reg + 2'h1;
            if (q_reg == 2'h3) begin
                case (state_reg)
                    H_START: begin
                        state_next = H_BIT;
                        idx_next = 4'h0;
                    end
                    H_BIT: begin
                        if (idx_reg == BITS_PER_BYTE) begin
                            // Acknowledge bit sampled at the end of its high phase
                            nack_next = sda_sync_reg[1];
                            state_next = stop_pend_reg ? H_STOP : H_IDLE;
                        end else begin
                            idx_next = idx_reg + 4'h1;
                            tx_next = {tx_reg[6:0], 1'b0};
                        end
                    end
                    default: begin
                        state_next = H_IDLE;
                    end
                endcase
            end
        end
        // Idle keeps the last levels so an open transfer keeps its clock state
        if (state_next == H_IDLE) begin
            lines_next = lines_reg;
        end else begin
            lines_next = line_levels(state_next, q_next, idx_next != BITS_PER_BYTE && !tx_next[7]);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= H_IDLE;
            div_reg <= 8'h00;
            q_reg <= 2'h0;
            idx_reg <= 4'h0;
            tx_reg <= 8'h00;
            stop_pend_reg <= 1'b0;
            lines_reg <= 2'b00;
            nack_reg <= 1'b0;
            cmd_reg <= 10'h000;
            aw_have_reg <= 1'b0;
            aw_addr_reg <= 4'h0;
            w_have_reg <= 1'b0;
            w_data_reg <= 32'h0;
            w_strb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0;
            rresp_reg <= RESP_OKAY;
        end else begin
            state_reg <= state_next;
            div_reg <= div_next;
            q_reg <= q_next;
            idx_reg <= idx_next;
            tx_reg <= tx_next;
            stop_pend_reg <= stop_pend_next;
            lines_reg <= lines_next;
            nack_reg <= nack_next;
            cmd_reg <= cmd_next;
            aw_have_reg <= aw_have_next;
            aw_addr_reg <= aw_addr_next;
            w_have_reg <= w_have_next;
            w_data_reg <= w_data_next;
            w_strb_reg <= w_strb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end

    assign link.scl_o = 1'b0;
    assign link.scl_oe = lines_reg[1];
    assign link.host_sda_o = 1'b0;
    assign link.host_sda_oe = lines_reg[0];
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;
endmodule : lcd_bus_controller
`default_nettype wire

// ==== sim/lcd_link_checker.sv ====
// Assertions on the shared two-wire link
`timescale 1ns/1ps
`default_nettype none
module lcd_link_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic host_sda_oe,
    input wire logic tgt_sda_oe,
    input wire logic scl,
    input wire logic sda
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ack_hold_a: assert property (scl && $past(scl) |-> $stable(tgt_sda_oe)) else $error("ack moved");
    ack_rise_a: assert property ($rose(tgt_sda_oe) |-> !scl && !$past(scl, 2)) else $error("ack early");
    ack_drop_a: assert property ($fell(scl) && tgt_sda_oe |-> ##[2:5] !tgt_sda_oe) else $error("ack kept");
    ack_reach_a: assert property ($rose(tgt_sda_oe) |-> tgt_sda_oe throughout (##[1:200] scl))
        else $error("ack short");
    start_idle_a: assert property ($fell(sda) && scl |-> $past(scl, 8) && !tgt_sda_oe) else $error("start");
    stop_idle_a: assert property ($rose(sda) && scl |-> $past(scl, 8)) else $error("stop");
    data_stable_a: assert property ($changed(host_sda_oe) |-> !scl || $past(scl, 20)) else $error("data");
    clk_phase_a: assert property ($changed(scl) |=> $stable(scl) [*8]) else $error("clock glitch");
    cover property ($rose(tgt_sda_oe));
    cover property ($fell(sda) && scl);
    cover property ($rose(sda) && scl);
endmodule : lcd_link_checker
`default_nettype wire

// ==== sim/segment_lcd_cmd_i2c_target_test.sv ====
// Bench for the bus controller and display target joined by the link
`timescale 1ns/1ps
`default_nettype none
module segment_lcd_cmd_i2c_target_test;
    import lcd_cmd_pkg::*;
    logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0, bready = 1'h1, rready = 1'h1;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, st;
    logic [1:0] rresp, rs, bresp, bs, blink_freq_field;
    logic awready, wready, bvalid, arready, rvalid, in_bank_sel, out_bank_sel, alt_bank_blink_bit;
    logic alt_blink_active, data_in_bank, data_wr, ext_cmd_valid, selected;
    logic [2:0] subaddr_count;
    logic [7:0] data_byte, ext_cmd_byte;
    drive_mode_t drive_mode = DRIVE_STATIC;
    int err_count = 0, checked = 0, wr_count = 0, ext_count = 0;
    lcd_link_if link ();
    lcd_bus_controller lcd_bus_controller_inst (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf),
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .link(link.controller));
    lcd_cmd_target lcd_cmd_target_inst (.aclk, .aresetn, .link(link.target), .hw_subaddr_pin_0(1'h0),
        .hw_subaddr_pin_1(1'h0), .hw_subaddr_pin_2(1'h0), .target_addr_select_pin(1'h0), .drive_mode,
        .subaddr_count, .in_bank_sel, .out_bank_sel, .alt_bank_blink_bit, .blink_freq_field, .alt_blink_active,
        .data_wr, .data_byte, .data_in_bank, .ext_cmd_valid, .ext_cmd_byte, .selected);
    lcd_link_checker lcd_link_checker_inst (.aclk, .aresetn, .host_sda_oe(link.host_sda_oe),
        .tgt_sda_oe(link.tgt_sda_oe), .scl(link.scl), .sda(link.sda));
    // Counts the one-cycle strobes of the target
    always @(posedge aclk) begin
        if (data_wr) wr_count <= wr_count + 1;
        if (ext_cmd_valid) ext_count <= ext_count + 1;
    end
    task automatic finish_test;
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : finish_test
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            err_count++;
            $display("[FAIL] %s exp %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!bvalid);
        bs = bresp;
    endtask : axi_wr
    task automatic axi_rd(input logic [3:0] a);
        araddr <= a;
        arvalid <= 1'h1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'h0;
        end while (!rvalid);
        st = rdata;
        rs = rresp;
    endtask : axi_rd
    // Bits 9 and 8 request STOP and START around the byte
    task automatic xfer(input logic [9:0] c, input logic n);
        axi_wr(4'h0, 32'(c));
        do axi_rd(4'h4); while (st[0]);
        chk("bresp", 32'(bs), 32'(RESP_OKAY));
        chk("nack", 32'(st[1]), 32'(n));
    endtask : xfer
    task automatic t_reset;
        chk("dflt", 32'({subaddr_count, in_bank_sel, out_bank_sel, alt_bank_blink_bit, blink_freq_field}), 32'h0);
        axi_rd(4'h8);
        chk("resp", 32'(rs), 32'(RESP_SLVERR));
        axi_wr(4'h8, 32'h0);
        chk("wresp", 32'(bs), 32'(RESP_SLVERR));
    endtask : t_reset
    task automatic t_devsel;
        xfer(10'h170, 1'h0);
        xfer(10'h0e5, 1'h0);
        chk("sub", 32'(subaddr_count), 32'h5);
        for (int i = 0; i < 4; i++) begin
            xfer(10'(8'hf0 + i), 1'h0);
            chk("freq", 32'(blink_freq_field), 32'(i));
        end
        xfer(10'h077, 1'h0);
        chk("alt", 32'({alt_bank_blink_bit, blink_freq_field}), 32'h7);
        xfer(10'h2a5, 1'h1);
    endtask : t_devsel
    task automatic t_bank;
        xfer(10'h170, 1'h0);
        chk("sel", 32'(selected), 32'h1);
        xfer(10'h0fb, 1'h0);
        chk("bank", 32'({in_bank_sel, out_bank_sel}), 32'h3);
        xfer(10'h0c5, 1'h0);
        chk("ext", 32'({ext_count[7:0], ext_cmd_byte}), 32'h1c5);
        xfer(10'h060, 1'h0);
        xfer(10'h23c, 1'h0);
        chk("data", 32'({data_in_bank, data_byte}), 32'h13c);
        chk("wrs", 32'(wr_count), 32'h1);
        chk("unsel", 32'(selected), 32'h0);
    endtask : t_bank
    // Ends in three-way drive, where bank switching is frozen
    task automatic t_mux;
        for (int i = 0; i < 4; i++) begin
            drive_mode <= 2'(i);
            repeat (3) @(posedge aclk);
            chk("altact", 32'(alt_blink_active), 32'(i == 1 || i == 2));
        end
        xfer(10'h170, 1'h0);
        xfer(10'h278, 1'h0);
        chk("frozen", 32'({in_bank_sel, out_bank_sel}), 32'h3);
        xfer(10'h372, 1'h1);
        xfer(10'h371, 1'h1);
    endtask : t_mux
    initial forever #10 aclk = ~aclk;
    initial begin
        #1000000;
        err_count++;
        finish_test;
    end
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        t_reset;
        t_devsel;
        t_bank;
        t_mux;
        finish_test;
    end
endmodule : segment_lcd_cmd_i2c_target_test
`default_nettype wire
